//--- rtl/hcur_overlay.sv
// hardware cursor overlay on the incoming pixel stream, with in-band bitmap capture
// assumes pixel clock, syncs and data arrive from outside and are sampled by clock
`timescale 1ns/1ps
`default_nettype none
`include "hcur_regs.svh"

module hcur_overlay (
	// system
	input wire logic clock,
	input wire logic nrst,
	// register port
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata_q,
	// graphics source pins
	input wire logic pix_clk,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic [23:0] pixel_data_port,
	output logic data_req_q,
	// overlay and converter outputs
	output hcur_pkg::hcur_rgb_t ovl_pix_q,
	output logic ovl_valid_q,
	output hcur_pkg::hcur_rgb_t dac_pix_q,
	output logic dac_valid_q
);
	// ****************************************
	// functions
	// ****************************************
	// two-bit pattern out of a bitmap byte
	function automatic logic [1:0] pick_pat(input logic [7:0] b, input logic [1:0] sel);
		logic [7:0] sh;
		sh = b >> {sel, 1'b0};
		pick_pat = sh[1:0];
	endfunction

	// colour of one dot for a given pattern
	function automatic hcur_pkg::hcur_rgb_t mix(input logic [1:0] pat, input logic cm,
		input hcur_pkg::hcur_rgb_t in, input hcur_pkg::hcur_rgb_t c1,
		input hcur_pkg::hcur_rgb_t c2, input hcur_pkg::hcur_rgb_t cx);
		case (hcur_pkg::hcur_pat_t'(pat))
			hcur_pkg::HCUR_PAT_COL2: mix = c2;
			hcur_pkg::HCUR_PAT_COL1: mix = c1;
			hcur_pkg::HCUR_PAT_CLEAR: mix = in;
			hcur_pkg::HCUR_PAT_SPECIAL: mix = cm ? cx : ~in;
			default: mix = in;
		endcase
	endfunction

	// offset of a coordinate from the cursor edge; a negative result wraps high
	function automatic logic [11:0] win_off(input logic [10:0] at, input logic [4:0] hot,
		input logic [10:0] pos);
		win_off = {1'b0, at} + {7'h00, hot} - {1'b0, pos};
	endfunction

	// ****************************************
	// registers
	// ****************************************
	hcur_pkg::hcur_ctrl_t ctrl_q;
	hcur_pkg::hcur_rgb_t col1_q, col2_q, colx_q;
	logic [4:0] hot_x_q, hot_y_q;
	logic [10:0] pos_x_q, pos_y_q, first_q, act_len_q, nlines_q;
	logic [7:0] bmp [0:255];

	// pin synchronisers and counters
	logic [2:0] pclk_s;
	logic [2:0] hs_s;
	logic [2:0] vs_s;
	logic [23:0] pdat_s1, pdat_s2;
	logic [10:0] pix_cnt_q, line_cnt_q, upl_cnt_q;

	// ****************************************
	// decode
	// ****************************************
	wire bmp_sel = (addr[11:10] == `HCUR_A_BMP_HI);
	wire [7:0] bmp_idx = addr[9:2];
	wire reg_wr = wr & ~bmp_sel;
	wire pe = pclk_s[1] & ~pclk_s[2];
	wire hs_rise = hs_s[1] & ~hs_s[2];
	wire vs_rise = vs_s[1] & ~vs_s[2];

	// line classes counted in input lines
	wire [10:0] tbl0_line = first_q - 11'h002;
	wire [10:0] tbl1_line = first_q - 11'h001;
	wire [10:0] act_line = line_cnt_q - first_q;
	wire upl_line = (line_cnt_q == tbl0_line) | (line_cnt_q == tbl1_line);
	wire act_row = (line_cnt_q >= first_q) & (act_line < nlines_q);
	wire req_line = act_row | (upl_line & ctrl_q.tlre);
	wire req_now = req_line & (pix_cnt_q < act_len_q);

	// in-band byte: low lane, cursor bytes follow the 768 table bytes
	wire upl_take = pe & req_now & upl_line & ctrl_q.tlre & (upl_cnt_q < `HCUR_UPL_BYTES);
	wire cur_byte = upl_cnt_q >= `HCUR_TBL_BYTES;
	wire [10:0] cur_off = upl_cnt_q - `HCUR_TBL_BYTES;
	wire inband_wr = upl_take & cur_byte & ctrl_q.inband;

	// cursor window relative to the hot spot, in input pixel units
	wire [11:0] dx = win_off(pix_cnt_q, hot_x_q, pos_x_q);
	wire [11:0] dy = win_off(act_line, hot_y_q, pos_y_q);
	// wrap of a negative offset lands far above 32, so it clips too
	wire in_cur = (dx < `HCUR_CUR_SIZE) & (dy < `HCUR_CUR_SIZE) & act_row;
	wire [7:0] rd_idx = {dy[4:0], dx[4:2]};
	wire [1:0] pat = pick_pat(bmp[rd_idx], dx[1:0]);
	wire hcur_pkg::hcur_rgb_t pix_in = pdat_s2;
	wire hcur_pkg::hcur_rgb_t pix_mix = mix(pat, ctrl_q.cursor_colour_mode_select, pix_in,
		col1_q, col2_q, colx_q);
	wire hcur_pkg::hcur_rgb_t pix_out = (ctrl_q.enable & in_cur) ? pix_mix : pix_in;

	// read data selection
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (bmp_sel) begin
			rd_mux = {24'h00_0000, bmp[bmp_idx]};
		end else begin
			case (addr)
				`HCUR_A_CTRL: rd_mux = {27'h000_0000, ctrl_q};
				`HCUR_A_COL1: rd_mux = {8'h00, col1_q};
				`HCUR_A_COL2: rd_mux = {8'h00, col2_q};
				`HCUR_A_COLX: rd_mux = {8'h00, colx_q};
				`HCUR_A_HOTX: rd_mux = {27'h000_0000, hot_x_q};
				`HCUR_A_HOTY: rd_mux = {27'h000_0000, hot_y_q};
				`HCUR_A_POSX: rd_mux = {21'h00_0000, pos_x_q};
				`HCUR_A_POSY: rd_mux = {21'h00_0000, pos_y_q};
				`HCUR_A_FIRST: rd_mux = {21'h00_0000, first_q};
				`HCUR_A_ACTLEN: rd_mux = {21'h00_0000, act_len_q};
				`HCUR_A_NLINES: rd_mux = {21'h00_0000, nlines_q};
				`HCUR_A_STATUS: rd_mux = {5'h00, upl_cnt_q, 5'h00, line_cnt_q};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// processes
	// ****************************************
	// software registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `HCUR_CTRL_RST;
			col1_q <= 24'h00_0000;
			col2_q <= 24'h00_0000;
			colx_q <= 24'h00_0000;
			hot_x_q <= 5'h00;
			hot_y_q <= 5'h00;
			pos_x_q <= 11'h000;
			pos_y_q <= 11'h000;
			first_q <= `HCUR_FIRST_RST;
			act_len_q <= `HCUR_ACTLEN_RST;
			nlines_q <= `HCUR_NLINES_RST;
		end else if (reg_wr) begin
			case (addr)
				`HCUR_A_CTRL: ctrl_q <= wdata[4:0];
				`HCUR_A_COL1: col1_q <= wdata[23:0];
				`HCUR_A_COL2: col2_q <= wdata[23:0];
				`HCUR_A_COLX: colx_q <= wdata[23:0];
				`HCUR_A_HOTX: hot_x_q <= wdata[4:0];
				`HCUR_A_HOTY: hot_y_q <= wdata[4:0];
				`HCUR_A_POSX: pos_x_q <= wdata[10:0];
				`HCUR_A_POSY: pos_y_q <= wdata[10:0];
				`HCUR_A_FIRST: first_q <= wdata[10:0];
				`HCUR_A_ACTLEN: act_len_q <= wdata[10:0];
				`HCUR_A_NLINES: nlines_q <= wdata[10:0];
				default: ;
			endcase
		end
	end

	// bitmap store; an in-band byte wins over a bus write in the same cycle
	always_ff @(posedge clock) begin
		if (inband_wr) begin
			bmp[cur_off[7:0]] <= pdat_s2[7:0];
		end else if (wr & bmp_sel) begin
			bmp[bmp_idx] <= wdata[7:0];
		end
	end

	// read data stands one cycle after the strobe
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rd ? rd_mux : 32'h0000_0000;
		end
	end

	// pin synchronisers, two stages before any use
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pclk_s <= 3'h0;
			hs_s <= 3'h0;
			vs_s <= 3'h0;
			pdat_s1 <= 24'h00_0000;
			pdat_s2 <= 24'h00_0000;
		end else begin
			pclk_s <= {pclk_s[1:0], pix_clk};
			hs_s <= {hs_s[1:0], hsync};
			vs_s <= {vs_s[1:0], vsync};
			pdat_s1 <= pixel_data_port;
			pdat_s2 <= pdat_s1;
		end
	end

	// pixel and line counters; first line after vsync is line 0
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pix_cnt_q <= 11'h000;
			line_cnt_q <= 11'h7FF;
		end else if (vs_rise) begin
			pix_cnt_q <= 11'h000;
			line_cnt_q <= 11'h7FF;
		end else if (hs_rise) begin
			pix_cnt_q <= 11'h000;
			line_cnt_q <= line_cnt_q + 11'h001;
		end else if (pe & (pix_cnt_q != 11'h7FF)) begin
			pix_cnt_q <= pix_cnt_q + 11'h001;
		end
	end

	// upload byte count spans both upload lines and restarts each field
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			upl_cnt_q <= 11'h000;
		end else if (vs_rise) begin
			upl_cnt_q <= 11'h000;
		end else if (upl_take) begin
			upl_cnt_q <= upl_cnt_q + 11'h001;
		end
	end

	// data request towards the graphics source
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			data_req_q <= 1'b0;
		end else begin
			data_req_q <= req_now;
		end
	end

	// overlay output, one word per accepted active pixel
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ovl_pix_q <= 24'h00_0000;
			ovl_valid_q <= 1'b0;
		end else begin
			ovl_valid_q <= pe & req_now & act_row;
			if (pe & req_now & act_row) begin
				ovl_pix_q <= pix_out;
			end
		end
	end

	// converter port only carries the overlay in auxiliary monitor mode
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dac_pix_q <= 24'h00_0000;
			dac_valid_q <= 1'b0;
		end else begin
			dac_valid_q <= pe & req_now & act_row & ctrl_q.aux_mon;
			if (pe & req_now & act_row & ctrl_q.aux_mon) begin
				dac_pix_q <= pix_out;
			end
		end
	end
endmodule

`default_nettype wire

//--- rtl/hcur_pkg.sv
// types shared by the cursor overlay
// assumes 8-bit red, green and blue components
package hcur_pkg;
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} hcur_rgb_t;

	typedef struct packed {
		logic aux_mon;
		logic tlre;
		logic inband;
		logic cursor_colour_mode_select;
		logic enable;
	} hcur_ctrl_t;

	typedef enum logic [1:0] {
		HCUR_PAT_COL2 = 2'b00,
		HCUR_PAT_COL1 = 2'b01,
		HCUR_PAT_CLEAR = 2'b10,
		HCUR_PAT_SPECIAL = 2'b11
	} hcur_pat_t;
endpackage

//--- rtl/hcur_regs.svh
// register offsets, control field positions, reset values and upload counts for the cursor overlay
// assumes a 12-bit byte address on a plain strobe port with 32-bit data
//
// Functional notes
// - a 32 by 32 cursor can be laid over the picture, its bitmap loaded by register writes or in-band.
// - in-band, the 256 bitmap bytes follow the last table byte in the line before the first active line.
// - every cursor pixel is two bits whose meaning depends on the colour mode select.
// - four pixels share a byte, first pixel in bits 1:0 and fourth in bits 7:6.
// - the column varies fastest, then the row, with byte 0 at the upper left corner.
// - 00 gives colour two, 01 colour one, 10 transparent, 11 inverted input or auxiliary colour.
// - transparent dots pass the input pixel and the three colours have their own registers.
// - each axis has a hot spot register inside the bitmap and a screen position register.
// - screen origin is upper left; hot spots past the right or bottom edge are clipped correctly.
// - cursor positions count input pixels and lines, before any scaling.
// - in auxiliary monitor mode the overlay output goes straight to the converter port.
// - the 768 table bytes come red, green, blue from the start of the line two before the first.
// - request pulses are issued on the two upload lines unless the table line request is cleared.
`ifndef HCUR_REGS_SVH
`define HCUR_REGS_SVH

// ****************************************
// register map
// ****************************************
`define HCUR_A_CTRL 12'h000
`define HCUR_A_COL1 12'h004
`define HCUR_A_COL2 12'h008
`define HCUR_A_COLX 12'h00C
`define HCUR_A_HOTX 12'h010
`define HCUR_A_HOTY 12'h014
`define HCUR_A_POSX 12'h018
`define HCUR_A_POSY 12'h01C
`define HCUR_A_FIRST 12'h020
`define HCUR_A_ACTLEN 12'h024
`define HCUR_A_NLINES 12'h028
`define HCUR_A_STATUS 12'h02C
`define HCUR_A_BMP_HI 2'h1

// ****************************************
// control fields and reset values
// ****************************************
`define HCUR_B_ENABLE 0
`define HCUR_B_COLOUR_MODE 1
`define HCUR_B_INBAND 2
`define HCUR_B_TLRE 3
`define HCUR_B_AUXMON 4
`define HCUR_CTRL_RST 5'h08
`define HCUR_FIRST_RST 11'h002
`define HCUR_ACTLEN_RST 11'h280
`define HCUR_NLINES_RST 11'h1E0

// ****************************************
// in-band upload counts
// ****************************************
`define HCUR_TBL_BYTES 11'h300
`define HCUR_UPL_BYTES 11'h400
`define HCUR_CUR_SIZE 12'h020

`endif

//--- verification/hcur_chk_sva.sv
// port checker for the cursor overlay
// assumes only the top ports of the overlay are visible
`timescale 1ns/1ps
`default_nettype none
module hcur_chk (
	// watched ports
	input wire logic clock,
	input wire logic nrst,
	input wire logic [11:0] addr,
	input wire logic rd,
	input wire logic [31:0] rdata_q,
	input wire logic pix_clk,
	input wire logic data_req_q,
	input wire hcur_pkg::hcur_rgb_t ovl_pix_q,
	input wire logic ovl_valid_q,
	input wire hcur_pkg::hcur_rgb_t dac_pix_q,
	input wire logic dac_valid_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// a pixel edge goes through sync and detect before its pixel shows
	sequence s_hole;
		rd && addr == 12'h030;
	endsequence
	sequence s_edge;
		$past(pix_clk, 3) && !$past(pix_clk, 6);
	endsequence
	property p_hole;
		s_hole |=> rdata_q == 32'h0;
	endproperty
	a_hole: assert property (p_hole) else $error("hole read not zero");
	property p_rd_idle;
		!$past(rd) |-> rdata_q == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_vpulse;
		ovl_valid_q |=> !ovl_valid_q;
	endproperty
	a_vpulse: assert property (p_vpulse) else $error("pixel valid too long");
	property p_vedge;
		ovl_valid_q |-> s_edge;
	endproperty
	a_vedge: assert property (p_vedge) else $error("pixel without edge");
	property p_vreq;
		ovl_valid_q |-> $past(data_req_q);
	endproperty
	a_vreq: assert property (p_vreq) else $error("pixel on unrequested line");
	property p_ohold;
		!ovl_valid_q |-> $stable(ovl_pix_q);
	endproperty
	a_ohold: assert property (p_ohold) else $error("overlay pixel moved");
	property p_dfollow;
		dac_valid_q |-> ovl_valid_q && dac_pix_q == ovl_pix_q;
	endproperty
	a_dfollow: assert property (p_dfollow) else $error("converter pixel differs");
	property p_dhold;
		!dac_valid_q |-> $stable(dac_pix_q);
	endproperty
	a_dhold: assert property (p_dhold) else $error("converter pixel moved");
endmodule
bind hcur_overlay hcur_chk u_chk (.clock, .nrst, .addr, .rd, .rdata_q, .pix_clk, .data_req_q,
	.ovl_pix_q, .ovl_valid_q, .dac_pix_q, .dac_valid_q);
`default_nettype wire

//--- verification/hcur_src.sv
// graphics source model driving syncs, pixel clock and pixel data
// assumes the bench calls its tasks one after another
`timescale 1ns/1ps
`default_nettype none
module hcur_src (
	// pixel port
	output var logic pix_clk,
	output var logic hsync,
	output var logic vsync,
	output var logic [23:0] pixel_data_port
);
	initial begin
		pix_clk = 1'b0;
		hsync = 1'b0;
		vsync = 1'b0;
		pixel_data_port = 24'h0;
	end
	// field start; pixel clock stands still outside lines
	task frame();
		#37 vsync = 1'b1; // off the sampling edge
		#800 vsync = 1'b0;
		#800;
	endtask
	// data held a whole period around each rise; table then bitmap bytes in order
	task line(input int n, input logic [23:0] base);
		#37 hsync = 1'b1;
		#800 hsync = 1'b0;
		#800;
		for (int p = 0; p < n; p++) begin
			pixel_data_port = base + 24'(p);
			#400 pix_clk = 1'b1;
			#400 pix_clk = 1'b0;
		end
		pixel_data_port = ~pixel_data_port; // released: never the last value
		#800;
	endtask
endmodule
`default_nettype wire

//--- verification/test_hardware_cursor_overlay.sv
// bench: register port, in-band bitmap upload, overlay colours
// assumes the source model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
`include "hcur_regs.svh"
module test_hardware_cursor_overlay;
	logic clock = 0;
	logic nrst = 0;
	logic [11:0] addr = 0;
	logic [31:0] wdata = 0;
	logic wr = 0;
	logic rd = 0;
	logic [31:0] rdata_q;
	wire pix_clk, hsync, vsync;
	wire [23:0] pdata;
	logic data_req_q, ovl_valid_q, dac_valid_q;
	hcur_pkg::hcur_rgb_t ovl_pix_q, dac_pix_q;
	int bad_count = 0;
	int n_checks = 0;
	int req_seen = 0;
	logic [23:0] got[$];
	logic [23:0] dgot[$];
	always #50 clock = ~clock;
	hcur_src u_src (.pix_clk(pix_clk), .hsync(hsync), .vsync(vsync), .pixel_data_port(pdata));
	hcur_overlay u_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata_q(rdata_q), .pix_clk(pix_clk), .hsync(hsync), .vsync(vsync),
		.pixel_data_port(pdata), .data_req_q(data_req_q), .ovl_pix_q(ovl_pix_q),
		.ovl_valid_q(ovl_valid_q), .dac_pix_q(dac_pix_q), .dac_valid_q(dac_valid_q));
	// capture overlaid pixels and any line request
	always @(posedge clock) begin
		if (ovl_valid_q === 1'b1)
			got.push_back(ovl_pix_q);
		if (dac_valid_q === 1'b1)
			dgot.push_back(dac_pix_q);
		if (data_req_q === 1'b1)
			req_seen++;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		n_checks++;
		if (seen !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task wreg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rchk(input logic [11:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk("rdata", rdata_q, e);
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// byte 0 rewritten by the bus, byte 1 left from the in-band upload
	// off moves the cursor right; left of it the input passes
	function automatic logic [23:0] expv(input int p, input logic cm, input int off);
		logic [7:0] b;
		logic [1:0] pat;
		logic [23:0] in;
		int q;
		q = p - off;
		in = 24'h5A3C10 + 24'(p);
		if (q < 0)
			return in;
		b = (q < 4) ? 8'hE4 : 8'h01;
		pat = 2'(b >> (2 * (q % 4)));
		case (pat)
			2'h0: return 24'h222222;
			2'h1: return 24'h111111;
			2'h2: return in;
			default: return cm ? 24'h333333 : ~in;
		endcase
	endfunction
	task vline(input logic cm, input logic aux, input int off);
		int g0;
		int d0;
		g0 = got.size();
		d0 = dgot.size();
		u_src.line(8, 24'h5A3C10);
		chk("count", 32'(got.size() - g0), 32'h8);
		chk("dac count", 32'(dgot.size() - d0), aux ? 32'h8 : 32'h0);
		for (int p = 0; p < 8; p++) begin
			chk("pixel", {8'h0, got[g0 + p]}, {8'h0, expv(p, cm, off)});
			if (aux)
				chk("dac pixel", {8'h0, dgot[d0 + p]}, {8'h0, expv(p, cm, off)});
		end
	endtask
	task t_reset();
		rchk(`HCUR_A_CTRL, 32'h08);
		rchk(`HCUR_A_FIRST, 32'h2);
		rchk(12'h030, 32'h0);
		$display("reset test done");
	endtask
	// whole-line uploads: line 1 pixel 256+j carries bitmap byte j
	task t_inband();
		int r0;
		wreg(`HCUR_A_ACTLEN, 32'h200);
		wreg(`HCUR_A_CTRL, 32'h0C);
		u_src.frame();
		r0 = req_seen;
		u_src.line(512, 24'h0);
		u_src.line(512, 24'h0);
		chk("upload request", 32'(req_seen > r0), 32'h1);
		rchk(`HCUR_A_STATUS, 32'h0400_0001);
		for (int j = 0; j < 256; j++)
			rchk(12'h400 + 12'(4 * j), 32'(j));
		$display("in-band test done");
	endtask
	task t_overlay();
		int r0;
		wreg(12'h400, 32'hE4);
		for (int i = 1; i < 4; i++)
			wreg(12'(4 * i), 32'h111111 * i);
		for (int a = 16; a < 32; a += 4)
			wreg(12'(a), 32'h0);
		wreg(`HCUR_A_CTRL, 32'h01);
		rchk(`HCUR_A_COL1, 32'h111111);
		u_src.frame();
		r0 = req_seen;
		u_src.line(8, 24'h0);
		u_src.line(8, 24'h0);
		chk("upload request", 32'(req_seen - r0), 32'h0);
		vline(1'b0, 1'b0, 0);
		wreg(`HCUR_A_CTRL, 32'h13);
		wreg(`HCUR_A_POSY, 32'h1);
		vline(1'b1, 1'b1, 0);
		// hot spot inside the bitmap, placed right of and below it
		wreg(`HCUR_A_HOTX, 32'h4);
		wreg(`HCUR_A_POSX, 32'h8);
		wreg(`HCUR_A_HOTY, 32'h3);
		wreg(`HCUR_A_POSY, 32'h5);
		vline(1'b1, 1'b1, 4);
		$display("overlay test done");
	endtask
	initial begin
		#3000000;
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_inband();
		t_overlay();
		end_sim();
	end
endmodule
`default_nettype wire
